// File: pciad_pkg.sv
// package of constants and types for the pci address/data/parity path
package pciad_pkg;
	localparam int ADW = 32;
	localparam int CBW = 4;
	// bus command codes
	localparam logic [3:0] CMD_IO_READ   = 4'h2;
	localparam logic [3:0] CMD_IO_WRITE  = 4'h3;
	localparam logic [3:0] CMD_MEM_READ  = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	localparam logic [3:0] CMD_CFG_READ  = 4'hA;
	localparam logic [3:0] CMD_CFG_WRITE = 4'hB;
	localparam int CMD_WRITE_BIT = 0;
	// byte-address bits dropped for dword spaces
	localparam logic [1:0] DWORD_LOW = 2'h0;
	// perr is reported this many clocks after detection
	localparam int PERR_DELAY = 2;
	localparam logic [31:0] AD_RESET = 32'h0000_0000;
	localparam logic [3:0]  CBE_RESET = 4'hF;
	typedef enum logic [1:0] {PCIAD_IO, PCIAD_MEM, PCIAD_CFG, PCIAD_OTHER} pciad_space_t;
	typedef enum {PCIAD_IDLE, PCIAD_ADDR, PCIAD_DATA, PCIAD_PARK, PCIAD_TURN} pciad_phase_t;

	function automatic logic evenPar(input logic [31:0] ad, input logic [3:0] cbe);
		return ^{ad, cbe};
	endfunction

	function automatic pciad_space_t spaceOf(input logic [3:0] cmd);
		case (cmd[3:1])
			CMD_IO_READ[3:1]:  return PCIAD_IO;
			CMD_MEM_READ[3:1]: return PCIAD_MEM;
			CMD_CFG_READ[3:1]: return PCIAD_CFG;
			default:           return PCIAD_OTHER;
		endcase
	endfunction
endpackage

// File: pciad_if.sv
// internal carrier between the main path and the sustained tri-state handover
`timescale 1ns/1ns
`default_nettype none
interface pciad_if;
	logic want;
	logic assertLow;
	logic out;
	logic oeN;
	logic busy;
	modport owner (output want, output assertLow, input out, input oeN, input busy);
	modport line  (input want, input assertLow, output out, output oeN, output busy);
endinterface
`default_nettype wire

// File: pciad_sts_line.sv
// one sustained tri-state line: park high before release, wait before taking
`timescale 1ns/1ns
`default_nettype none
module pciad_sts_line
	import pciad_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic reset,
	pciad_if.line     ctl
);
	typedef enum {PCIAD_S_FREE, PCIAD_S_WAIT, PCIAD_S_OWN, PCIAD_S_PARK} pciad_sts_t;
	pciad_sts_t state;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state   <= PCIAD_S_FREE;
			ctl.out <= 1'b1;
			ctl.oeN <= 1'b1;
		end else begin
			unique case (state)
				PCIAD_S_FREE: begin
					ctl.oeN <= 1'b1;
					// one idle clock after release before driving low
					if (ctl.want) state <= PCIAD_S_WAIT;
				end
				PCIAD_S_WAIT: begin
					state   <= PCIAD_S_OWN;
					ctl.oeN <= 1'b0;
					ctl.out <= ~ctl.assertLow;
				end
				PCIAD_S_OWN: begin
					ctl.out <= ~ctl.assertLow;
					if (!ctl.want) begin
						// drive high one clock before floating
						state   <= PCIAD_S_PARK;
						ctl.out <= 1'b1;
					end
				end
				PCIAD_S_PARK: begin
					state   <= PCIAD_S_FREE;
					ctl.oeN <= 1'b1;
				end
			endcase
		end
	end
	assign ctl.busy = (state != PCIAD_S_FREE);
endmodule
`default_nettype wire

// File: pciad_path.sv
// pci address/data, command/byte-enable and parity path of the bus interface
`timescale 1ns/1ns
`default_nettype none
module pciad_path
	import pciad_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	// pins, split into input / output / output enable (low = driving)
	input  wire logic [31:0] adIn,
	output logic      [31:0] adOut,
	output logic             adOeN,
	input  wire logic [3:0]  cbeNIn,
	output logic      [3:0]  cbeNOut,
	output logic             cbeOeN,
	input  wire logic        parIn,
	output logic             parOut,
	output logic             parOeN,
	input  wire logic        frameNIn,
	input  wire logic        irdyNIn,
	input  wire logic        trdyNIn,
	output logic             irdyNOut,
	output logic             irdyOeN,
	output logic             perrNOut,
	output logic             perrOeN,
	output logic             serrNOut,
	output logic             serrOeN,
	// user side: initiator requests
	input  wire logic        mstStart,
	input  wire logic [3:0]  mstCmd,
	input  wire logic [31:0] mstAddr,
	input  wire logic [31:0] mstWData,
	input  wire logic [3:0]  mstBeN,
	input  wire logic        mstLast,
	// user side: target read selection and data
	input  wire logic        tgtReadSel,
	input  wire logic [31:0] tgtRData,
	// user side: observed transaction
	output logic             addrValid,
	output logic      [3:0]  addrCmd,
	output logic      [31:0] addrDecoded,
	output logic             dataValid,
	output logic      [31:0] dataWord,
	output logic      [3:0]  dataBeN,
	output logic             addrParErr,
	output logic             dataParErr
);
	// pin inputs through two flip-flops
	logic [31:0] adS1, adS;
	logic [3:0]  cbeS1, cbeS;
	logic        parS1, parS, frameS1, frameS, irdyS1, irdyS, trdyS1, trdyS;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			adS1 <= AD_RESET;
			adS <= AD_RESET;
			cbeS1 <= CBE_RESET;
			cbeS <= CBE_RESET;
			{parS1, parS, frameS1, frameS} <= 4'hF;
			{irdyS1, irdyS, trdyS1, trdyS} <= 4'hF;
		end else begin
			adS1 <= adIn;
			adS <= adS1;
			cbeS1 <= cbeNIn;
			cbeS <= cbeS1;
			parS1 <= parIn;
			parS <= parS1;
			frameS1 <= frameNIn;
			frameS <= frameS1;
			irdyS1 <= irdyNIn;
			irdyS <= irdyS1;
			trdyS1 <= trdyNIn;
			trdyS <= trdyS1;
		end
	end

	logic frameD;
	logic dataDone;
	logic addrPhase;
	assign dataDone  = !irdyS && !trdyS;
	assign addrPhase = frameD && !frameS;

	// receive side: address and data capture
	logic        inXfer, isWrite, chkAddr, chkData;
	logic [35:0] lastRx;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			frameD <= 1'b1;
			inXfer <= 1'b0;
			isWrite <= 1'b0;
			addrValid <= 1'b0;
			addrCmd <= CBE_RESET;
			addrDecoded <= AD_RESET;
			dataValid <= 1'b0;
			dataWord <= AD_RESET;
			dataBeN <= CBE_RESET;
			chkAddr <= 1'b0;
			chkData <= 1'b0;
			lastRx <= {AD_RESET, CBE_RESET};
		end else begin
			frameD <= frameS;
			addrValid <= addrPhase;
			dataValid <= 1'b0;
			chkAddr <= addrPhase;
			chkData <= 1'b0;
			if (addrPhase) begin
				inXfer <= 1'b1;
				isWrite <= cbeS[CMD_WRITE_BIT];
				addrCmd <= cbeS;
				lastRx <= {adS, cbeS};
				// dword spaces ignore the two low address bits
				if (spaceOf(cbeS) == PCIAD_IO) addrDecoded <= adS;
				else addrDecoded <= {adS[31:2], DWORD_LOW};
			end else if (inXfer && dataDone) begin
				dataValid <= 1'b1;
				dataWord <= adS;
				dataBeN <= cbeS;
				if (isWrite) begin
					chkData <= 1'b1;
					lastRx <= {adS, cbeS};
				end
				if (frameS) inXfer <= 1'b0;
			end
		end
	end

	// parity check one clock later; report pipeline for perr
	logic [PERR_DELAY-1:0] perrPipe;
	logic                  parBad, dataErrNow;
	assign parBad     = evenPar(lastRx[35:4], lastRx[3:0]) != parS;
	assign dataErrNow = chkData && parBad;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			addrParErr <= 1'b0;
			dataParErr <= 1'b0;
			perrPipe <= '0;
			perrNOut <= 1'b1;
			perrOeN <= 1'b1;
			serrNOut <= 1'b1;
			serrOeN <= 1'b1;
		end else begin
			addrParErr <= chkAddr && parBad;
			dataParErr <= dataErrNow;
			// pipe starts at detection, so perr falls two clocks after the error flag
			perrPipe <= {perrPipe[PERR_DELAY-2:0], dataErrNow};
			// pulse of one clock per bad phase; drives high after to park
			perrNOut <= !perrPipe[PERR_DELAY-1];
			perrOeN <= !(perrPipe[PERR_DELAY-1] || !perrNOut);
			// open drain: only enable while low
			serrOeN <= !addrParErr;
			serrNOut <= !addrParErr;
		end
	end

	// drive side
	pciad_if irdyCtl();
	pciad_sts_line uIrdy (
		.core_clk (core_clk),
		.reset    (reset),
		.ctl      (irdyCtl)
	);

	pciad_phase_t phase;
	logic         mstWrite, lastHeld, parPend;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			phase <= PCIAD_IDLE;
			adOut <= AD_RESET;
			cbeNOut <= CBE_RESET;
			adOeN <= 1'b1;
			cbeOeN <= 1'b1;
			parOut <= 1'b0;
			parOeN <= 1'b1;
			parPend <= 1'b0;
			mstWrite <= 1'b0;
			lastHeld <= 1'b0;
			irdyCtl.want <= 1'b0;
			irdyCtl.assertLow <= 1'b0;
		end else begin
			// parity of the word driven last clock
			parPend <= 1'b0;
			// on a target read the enables on the bus are the initiator's, not ours
			if (parPend) parOut <= evenPar(adOut, cbeOeN ? cbeS : cbeNOut);
			unique case (phase)
				PCIAD_IDLE: begin
					if (mstStart && !irdyCtl.busy) begin
						phase <= PCIAD_ADDR;
						adOut <= mstAddr;
						cbeNOut <= mstCmd;
						adOeN <= 1'b0;
						cbeOeN <= 1'b0;
						parPend <= 1'b1;
						mstWrite <= mstCmd[CMD_WRITE_BIT];
						lastHeld <= mstLast;
						irdyCtl.want <= 1'b1;
					end else if (tgtReadSel && inXfer && !isWrite) begin
						phase <= PCIAD_DATA;
						adOut <= tgtRData;
						adOeN <= 1'b0;
						mstWrite <= 1'b0;
					end
				end
				PCIAD_ADDR: begin
					phase <= PCIAD_DATA;
					parOeN <= 1'b0;
					cbeNOut <= mstBeN;
					irdyCtl.assertLow <= 1'b1;
					if (mstWrite) begin
						adOut <= mstWData;
						parPend <= 1'b1;
					end else adOeN <= 1'b1;
				end
				PCIAD_DATA: begin
					if (!irdyCtl.busy && !adOeN) begin
						// target read data, parity after trdy
						parOeN <= 1'b0;
						if (!trdyS) parPend <= 1'b1;
					end
					if (dataDone) begin
						// hold ad one clock and parity two clocks past completion
						phase <= PCIAD_PARK;
						irdyCtl.want <= 1'b0;
						irdyCtl.assertLow <= 1'b0;
					end else if (!cbeOeN && mstWrite) begin
						adOut <= mstWData;
						cbeNOut <= mstBeN;
						parPend <= 1'b1;
					end
				end
				PCIAD_PARK: begin
					phase <= PCIAD_TURN;
					adOeN <= 1'b1;
					cbeOeN <= 1'b1;
				end
				PCIAD_TURN: begin
					phase <= PCIAD_IDLE;
					parOeN <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			irdyNOut <= 1'b1;
			irdyOeN <= 1'b1;
		end else begin
			irdyNOut <= irdyCtl.out;
			irdyOeN <= irdyCtl.oeN;
		end
	end
endmodule
`default_nettype wire

// File: pciad_path_monitor.sv
// port assertions for the pci address/data/parity path
`timescale 1ns/1ns
`default_nettype none
module pciad_path_monitor
	import pciad_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic [31:0] adOut,
	input wire logic        adOeN,
	input wire logic [3:0]  cbeNOut,
	input wire logic        cbeOeN,
	input wire logic        parOut,
	input wire logic        parOeN,
	input wire logic        irdyNOut,
	input wire logic        irdyOeN,
	input wire logic        perrNOut,
	input wire logic        serrNOut,
	input wire logic        serrOeN,
	input wire logic        addrValid,
	input wire logic [3:0]  addrCmd,
	input wire logic [31:0] addrDecoded,
	input wire logic        addrParErr,
	input wire logic        dataParErr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_par_even: assert property (!parOeN && $past(!adOeN && !cbeOeN) |->
		parOut == ^{$past(adOut), $past(cbeNOut)}) else $error("parity not even");
	a_par_owner: assert property (!parOeN |-> $past(!adOeN))
		else $error("parity driven without ad the clock before");
	a_serr_cause: assert property (addrParErr |=> !serrNOut && !serrOeN)
		else $error("serr missing after address error");
	a_serr_single: assert property (!serrNOut |=> serrNOut)
		else $error("serr low longer than one clock");
	a_serr_drain: assert property (!serrOeN |-> !serrNOut)
		else $error("serr driven high");
	a_perr_delay: assert property (dataParErr |-> ##2 !perrNOut)
		else $error("perr not low two clocks after data error");
	a_dword_addr: assert property (addrValid && addrCmd[3:1] != CMD_IO_READ[3:1] |->
		addrDecoded[1:0] == DWORD_LOW) else $error("dword address keeps low bits");
	a_irdy_park: assert property ($rose(irdyOeN) |-> $past(irdyNOut) && !$past(irdyOeN))
		else $error("irdy floated without a high clock");
endmodule
`default_nettype wire

// File: pciad_agent.sv
// far-side pci agent: completes device transfers and issues its own
`timescale 1ns/1ns
`default_nettype none
module pciad_agent
	import pciad_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic [3:0]  lag,
	input  wire logic [31:0] adOut,
	input  wire logic        adOeN,
	input  wire logic [3:0]  cbeNOut,
	input  wire logic        cbeOeN,
	input  wire logic        parOut,
	input  wire logic        parOeN,
	input  wire logic        irdyNOut,
	input  wire logic        irdyOeN,
	output logic      [31:0] adIn,
	output logic      [3:0]  cbeNIn,
	output logic             parIn,
	output logic             frameNIn,
	output logic             irdyNIn,
	output logic             trdyNIn
);
	logic [31:0] ad = 32'h0000_0000;
	logic [3:0]  cbe = 4'hF;
	logic        par = 1'b0;
	logic        frameN = 1'b1;
	logic        irdyN = 1'b1;
	logic        trdyN = 1'b1;
	logic        ansN = 1'b1;
	logic        done = 1'b0;
	logic [3:0]  cnt = 4'h0;
	// freed ad/par have no pull: they show the inverse of the last value
	assign adIn = adOeN ? ad : adOut;
	assign cbeNIn = cbeOeN ? cbe : cbeNOut;
	assign parIn = parOeN ? par : parOut;
	assign frameNIn = frameN;
	assign irdyNIn = irdyOeN ? irdyN : irdyNOut;
	assign trdyNIn = trdyN & ansN;
	// one completion per irdy assertion, after lag clocks
	always @(negedge core_clk) begin
		ansN <= 1'b1;
		if (irdyOeN || irdyNOut) begin
			done <= 1'b0;
			cnt <= 4'h0;
		end else if (!done) begin
			if (cnt == lag) begin
				ansN <= 1'b0;
				done <= 1'b1;
			end else
				cnt <= cnt + 4'h1;
		end
	end
	task automatic issue(input logic [3:0] cmd, input logic [31:0] addr,
		input logic [31:0] data, input logic [3:0] be, input logic badA, input logic badD);
		@(negedge core_clk);
		frameN = 1'b0;
		ad = addr;
		cbe = cmd;
		@(negedge core_clk);
		frameN = 1'b1;
		par = ^{addr, cmd} ^ badA;
		ad = cmd[CMD_WRITE_BIT] ? data : ~addr;
		cbe = be;
		irdyN = 1'b0;
		trdyN = 1'b0;
		// a read holds both readies until the device has put its data out
		if (!cmd[CMD_WRITE_BIT]) begin
			@(negedge core_clk);
			for (int i = 0; i < 8 && adOeN; i++) @(negedge core_clk);
		end
		@(negedge core_clk);
		par = cmd[CMD_WRITE_BIT] ? ^{data, be} ^ badD : ~par;
		irdyN = 1'b1;
		trdyN = 1'b1;
		@(negedge core_clk);
		ad = ~ad;
		par = ~par;
	endtask
endmodule
`default_nettype wire

// File: pci_addr_data_parity_path_bench.sv
// self-checking bench for the pci address/data/parity path
`timescale 1ns/1ns
`default_nettype none
module pci_addr_data_parity_path_bench
	import pciad_pkg::*;
;
	logic core_clk = 1'b0, reset = 1'b1, mstStart = 1'b0, mstLast = 1'b1, tgtReadSel = 1'b0;
	logic [3:0] lag = 4'h0, mstCmd = 4'h0, mstBeN = 4'hF, addrCmd, dataBeN, cbeNIn, cbeNOut;
	logic [31:0] mstAddr = 32'h1234_5678, mstWData = 32'hA1B2_C3D4, tgtRData = 32'hCAFE_0123;
	logic [31:0] adIn, adOut, addrDecoded, dataWord, sDec, sWord, sRd;
	logic adOeN, cbeOeN, parIn, parOut, parOeN, frameNIn, irdyNIn, trdyNIn, irdyNOut, irdyOeN;
	logic perrNOut, perrOeN, serrNOut, serrOeN, addrValid, dataValid, addrParErr, dataParErr;
	logic gA, gD, gR, gS, gP, sRdPar;
	logic [3:0] sCmd, sBe;
	int n_errors = 0, samples_checked = 0, cycles = 0;
	pciad_path dut_u (.*);
	pciad_agent agent_u (.core_clk(core_clk), .lag(lag), .adOut(adOut), .adOeN(adOeN),
		.cbeNOut(cbeNOut), .cbeOeN(cbeOeN), .parOut(parOut), .parOeN(parOeN),
		.irdyNOut(irdyNOut), .irdyOeN(irdyOeN), .adIn(adIn), .cbeNIn(cbeNIn),
		.parIn(parIn), .frameNIn(frameNIn), .irdyNIn(irdyNIn), .trdyNIn(trdyNIn));
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (addrValid) {gA, sCmd, sDec} = {1'b1, addrCmd, addrDecoded};
		if (dataValid) {gD, sWord, sBe} = {1'b1, dataWord, dataBeN};
		if (!adOeN && tgtReadSel) {gR, sRd} = {1'b1, adOut};
		if (!serrNOut && addrParErr === 1'b0) gS = 1'b1;
		if (!perrNOut && !perrOeN) gP = 1'b1;
		if (!parOeN && cbeOeN) sRdPar = parOut;
		if (cycles > 5000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic waitFor(ref logic s, input logic v);
		for (int i = 0; i < 40 && s !== v; i++) @(negedge core_clk);
	endtask
	task automatic testMaster(input logic [3:0] lagV, input logic [3:0] cmd);
		{lag, mstCmd, mstStart} = {lagV, cmd, 1'b1};
		@(negedge core_clk);
		mstStart = 1'b0;
		waitFor(adOeN, 1'b0);
		check("addr phase", {adOut, cbeNOut}, {mstAddr, cmd});
		@(negedge core_clk);
		check("data phase", {adOut, cbeNOut}, {mstWData, mstBeN});
		waitFor(irdyOeN, 1'b0);
		check("irdy asserted", irdyNOut, 1'b0);
		waitFor(irdyOeN, 1'b1);
		check("irdy freed", {irdyOeN, adOeN, cbeOeN, parOeN}, 4'hF);
		repeat (6) @(negedge core_clk);
		$display("done master %h", cmd);
	endtask
	task automatic testTarget(input logic [3:0] cmd, input logic badA, input logic badD);
		logic [31:0] a;
		a = 32'h0000_1003;
		{gA, gD, gR, gS, gP} = 5'h00;
		sRdPar = 1'bx;
		tgtReadSel = !cmd[CMD_WRITE_BIT];
		agent_u.issue(cmd, a, 32'h8421_0F5A, 4'h6, badA, badD);
		waitFor(gA, 1'b1);
		check("cmd", sCmd, cmd);
		check("decoded", sDec, cmd[3:1] == CMD_IO_READ[3:1] ? a : {a[31:2], DWORD_LOW});
		if (badA) begin
			waitFor(gS, 1'b1);
			check("serr", gS, 1'b1);
		end else if (badD) begin
			waitFor(gP, 1'b1);
			check("perr", gP, 1'b1);
		end else if (cmd[CMD_WRITE_BIT]) begin
			waitFor(gD, 1'b1);
			check("write data", {sWord, sBe}, {32'h8421_0F5A, 4'h6});
		end else begin
			waitFor(gR, 1'b1);
			check("read data", sRd, tgtRData);
		end
		tgtReadSel = 1'b0;
		repeat (8) @(negedge core_clk);
		if (!cmd[CMD_WRITE_BIT])
			check("read parity", sRdPar, ^{tgtRData, 4'h6});
		$display("done target %h", cmd);
	endtask
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge core_clk);
		reset = 1'b0;
		@(negedge core_clk);
		testTarget(CMD_IO_READ, 1'b0, 1'b0);
		testTarget(CMD_IO_WRITE, 1'b0, 1'b0);
		testTarget(CMD_MEM_READ, 1'b0, 1'b0);
		testTarget(CMD_MEM_WRITE, 1'b0, 1'b0);
		testTarget(CMD_CFG_READ, 1'b0, 1'b0);
		testTarget(CMD_CFG_WRITE, 1'b0, 1'b0);
		testTarget(CMD_MEM_WRITE, 1'b1, 1'b0);
		testTarget(CMD_CFG_WRITE, 1'b0, 1'b1);
		testMaster(4'h0, CMD_MEM_WRITE);
		testMaster(4'h3, CMD_IO_WRITE);
		tally_and_finish();
	end
endmodule
bind pciad_path pciad_path_monitor mon_u (.core_clk(core_clk), .reset(reset),
	.adOut(adOut), .adOeN(adOeN), .cbeNOut(cbeNOut), .cbeOeN(cbeOeN), .parOut(parOut),
	.parOeN(parOeN), .irdyNOut(irdyNOut), .irdyOeN(irdyOeN), .perrNOut(perrNOut),
	.serrNOut(serrNOut), .serrOeN(serrOeN), .addrValid(addrValid), .addrCmd(addrCmd),
	.addrDecoded(addrDecoded), .addrParErr(addrParErr), .dataParErr(dataParErr));
`default_nettype wire
